//--- rtl/cdmod_axi_regs.sv
// AXI4-Lite slave holding the four modulator registers
`timescale 1ns/1ps
module cdmod_axi_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire cdmod_pkg::cdmod_axi_req_type axi_req,
	output cdmod_pkg::cdmod_axi_rsp_type axi_rsp,
	input wire logic output_readback,
	output logic [7:0] control_r,
	output logic [7:0] source_r,
	output logic [7:0] high_r,
	output logic [7:0] low_r
);
	import cdmod_pkg::*;
	logic [7:0] control_nxt, source_nxt, high_nxt, low_nxt;
	logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
	logic [3:0] awaddr_r, awaddr_nxt;
	logic [7:0] wbyte_r, wbyte_nxt;
	logic wlane_r, wlane_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic do_write, do_read;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val, input logic [7:0] mask);
		return (old & ~mask) | (val & mask);
	endfunction : merge

	assign axi_rsp.awready = ~aw_held_r & ~bvalid_r;
	assign axi_rsp.wready = ~w_held_r & ~bvalid_r;
	assign axi_rsp.bvalid = bvalid_r;
	assign axi_rsp.bresp = bresp_r;
	assign axi_rsp.arready = ~rvalid_r;
	assign axi_rsp.rvalid = rvalid_r;
	assign axi_rsp.rdata = rdata_r;
	assign axi_rsp.rresp = rresp_r;

	always_comb begin
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		awaddr_nxt = awaddr_r;
		wbyte_nxt = wbyte_r;
		wlane_nxt = wlane_r;
		if (axi_req.awvalid && axi_rsp.awready) begin
			aw_held_nxt = 1'b1;
			awaddr_nxt = axi_req.awaddr;
		end
		if (axi_req.wvalid && axi_rsp.wready) begin
			w_held_nxt = 1'b1;
			wbyte_nxt = axi_req.wdata[7:0];
			wlane_nxt = axi_req.wstrb[0];
		end
		do_write = aw_held_nxt & w_held_nxt & ~bvalid_r;
		control_nxt = control_r;
		source_nxt = source_r;
		high_nxt = high_r;
		low_nxt = low_r;
		bvalid_nxt = bvalid_r & ~axi_req.bready;
		bresp_nxt = bresp_r;
		if (do_write) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = CDMOD_RESP_OKAY;
			// [RULE6] Unimplemented bits masked
			case (awaddr_nxt)
				CDMOD_OFS_CONTROL: if (wlane_nxt) control_nxt = merge(control_r, wbyte_nxt, CDMOD_CON_WMASK);
				CDMOD_OFS_SOURCE: if (wlane_nxt) source_nxt = merge(source_r, wbyte_nxt, CDMOD_SRC_WMASK);
				CDMOD_OFS_HIGH_CARRIER: if (wlane_nxt) high_nxt = merge(high_r, wbyte_nxt, CDMOD_CAR_WMASK);
				CDMOD_OFS_LOW_CARRIER: if (wlane_nxt) low_nxt = merge(low_r, wbyte_nxt, CDMOD_CAR_WMASK);
				default: bresp_nxt = CDMOD_RESP_SLVERR;
			endcase
		end
		do_read = axi_req.arvalid & ~rvalid_r;
		rvalid_nxt = rvalid_r & ~axi_req.rready;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (do_read) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = CDMOD_RESP_OKAY;
			rdata_nxt = '0;
			case (axi_req.araddr)
				// [RULE3] Live output readback
				CDMOD_OFS_CONTROL: begin
					rdata_nxt[7:0] = control_r;
					rdata_nxt[CDMOD_CON_READBACK_BIT] = output_readback;
				end
				CDMOD_OFS_SOURCE: rdata_nxt[7:0] = source_r;
				CDMOD_OFS_HIGH_CARRIER: rdata_nxt[7:0] = high_r;
				CDMOD_OFS_LOW_CARRIER: rdata_nxt[7:0] = low_r;
				default: rresp_nxt = CDMOD_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		// [RULE18] Reset to defaults
		if (!aresetn) begin
			control_r <= CDMOD_CON_RESET;
			source_r <= CDMOD_SRC_RESET;
			high_r <= CDMOD_CAR_RESET;
			low_r <= CDMOD_CAR_RESET;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wbyte_r <= '0;
			wlane_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= CDMOD_RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= CDMOD_RESP_OKAY;
			rdata_r <= '0;
		end else begin
			control_r <= control_nxt;
			source_r <= source_nxt;
			high_r <= high_nxt;
			low_r <= low_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awaddr_r <= awaddr_nxt;
			wbyte_r <= wbyte_nxt;
			wlane_r <= wlane_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end
endmodule : cdmod_axi_regs

//--- rtl/cdmod_pkg.sv
// Package: register map, field layout and source codes of the carrier data modulator
package cdmod_pkg;
	localparam logic [3:0] CDMOD_OFS_CONTROL = 4'h0;
	localparam logic [3:0] CDMOD_OFS_SOURCE = 4'h4;
	localparam logic [3:0] CDMOD_OFS_HIGH_CARRIER = 4'h8;
	localparam logic [3:0] CDMOD_OFS_LOW_CARRIER = 4'hC;
	localparam int CDMOD_CON_ENABLE_BIT = 7;
	localparam int CDMOD_CON_INVERT_BIT = 4;
	localparam int CDMOD_CON_READBACK_BIT = 3;
	localparam int CDMOD_CON_SWVAL_BIT = 0;
	localparam int CDMOD_CAR_INVERT_BIT = 6;
	localparam int CDMOD_CAR_SYNC_BIT = 5;
	localparam logic [7:0] CDMOD_CON_WMASK = 8'h91;
	localparam logic [7:0] CDMOD_SRC_WMASK = 8'h0F;
	localparam logic [7:0] CDMOD_CAR_WMASK = 8'h6F;
	localparam logic [7:0] CDMOD_CON_RESET = 8'h00;
	localparam logic [7:0] CDMOD_SRC_RESET = 8'h00;
	localparam logic [7:0] CDMOD_CAR_RESET = 8'h00;
	localparam logic [1:0] CDMOD_RESP_OKAY = 2'h0;
	localparam logic [1:0] CDMOD_RESP_SLVERR = 2'h2;
	localparam logic [3:0] CDMOD_SEL_NONE_A = 4'h9;

	// Modulator-source inputs, index is selection code minus one for 0001-1000, minus two for 1010-1101
	typedef struct packed {
		logic logic_cell_two_out;
		logic logic_cell_one_out;
		logic numeric_oscillator_out;
		logic async_serial_tx;
		logic spi_data_out;
		logic comparator_two_out;
		logic comparator_one_out;
		logic pulse_unit_six_out;
		logic pulse_unit_five_out;
		logic capture_unit_two_out;
		logic capture_unit_one_out;
		logic modulator_input_pin;
	} cdmod_mod_src_type;

	// Carrier-source inputs
	typedef struct packed {
		logic logic_cell_two_out;
		logic logic_cell_one_out;
		logic fast_internal_oscillator;
		logic system_clock;
		logic numeric_oscillator_out;
		logic pulse_unit_six_out;
		logic pulse_unit_five_out;
		logic capture_unit_two_out;
		logic capture_unit_one_out;
		logic reference_clock_out;
		logic carrier_pin_two;
		logic carrier_pin_one;
	} cdmod_car_src_type;

	typedef struct packed {
		logic awvalid;
		logic [3:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [3:0] araddr;
		logic rready;
	} cdmod_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cdmod_axi_rsp_type;

	// Code to 12-input vector: 0000 gives the fallback, 1001/1110/1111 give low
	function automatic logic cdmod_pick(input logic [11:0] vec, input logic [3:0] code, input logic zero_val);
		logic r;
		r = 1'b0;
		case (code)
			4'h0: r = zero_val;
			4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: r = vec[code - 4'h1];
			4'hA, 4'hB, 4'hC, 4'hD: r = vec[code - 4'h2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : cdmod_pick
endpackage : cdmod_pkg

//--- rtl/cdmod_sync.sv
// Two-flop synchroniser with falling-edge pulse
`timescale 1ns/1ps
module cdmod_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic async_in,
	output logic sync_out,
	output logic fall_pulse
);
	import cdmod_pkg::*;
	logic meta_r, meta_nxt;
	logic stage_r, stage_nxt;
	logic prev_r, prev_nxt;

	always_comb begin
		meta_nxt = async_in;
		stage_nxt = meta_r;
		prev_nxt = stage_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= 1'b0;
			stage_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			stage_r <= stage_nxt;
			prev_r <= prev_nxt;
		end
	end

	assign sync_out = stage_r;
	assign fall_pulse = prev_r & ~stage_r;
endmodule : cdmod_sync

//--- rtl/cdmod_top.sv
// Carrier data modulator: source selection, carrier sync and output mixing
`timescale 1ns/1ps

// Function
// [RULE1] Enable bit gates all mixing
// [RULE2] Polarity bit inverts output, idle high
// [RULE3] Control bit 3 reads live output
// [RULE4] Readback sampled, may miss fast signals
// [RULE5] Software bit used only for code 0000
// [RULE6] Unimplemented bits ignore writes, read zero
// [RULE7] Modulator source code table
// [RULE8] Reserved codes connect nothing
// [RULE9] High carrier source code table
// [RULE10] Low carrier uses same encoding
// [RULE11] High carrier optional inversion
// [RULE12] Low carrier optional inversion
// [RULE13] High sync waits high falling edge
// [RULE14] Low sync waits low falling edge
// [RULE15] Modulator high picks high carrier
// [RULE16] Disabled forces ground and software bit
// [RULE17] Handover: leave late, return on edge
// [RULE18] Reset disables and restores defaults
// [RULE19] Synchronise sources before edge detection
module cdmod_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire cdmod_pkg::cdmod_axi_req_type axi_req,
	output cdmod_pkg::cdmod_axi_rsp_type axi_rsp,
	input wire cdmod_pkg::cdmod_mod_src_type mod_sources,
	input wire cdmod_pkg::cdmod_car_src_type carrier_sources,
	output logic modulated_out
);
	import cdmod_pkg::*;

	typedef enum logic [2:0] {
		CDMOD_ST_IDLE = 3'b001,
		CDMOD_ST_ON = 3'b010,
		CDMOD_ST_WAIT = 3'b100
	} cdmod_gate_type;

	logic [7:0] control_r, source_r, high_r, low_r;
	logic enable, sw_value, out_invert;
	logic mod_raw, high_raw, low_raw;
	logic mod_s, high_s, low_s;
	logic high_fall, low_fall;
	logic high_car, low_car;
	logic high_sync, low_sync;
	cdmod_gate_type high_st_r, high_st_nxt, low_st_r, low_st_nxt;
	logic mixed;
	logic out_r, out_nxt;

	cdmod_axi_regs u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.axi_req(axi_req),
		.axi_rsp(axi_rsp),
		.output_readback(out_r),
		.control_r(control_r),
		.source_r(source_r),
		.high_r(high_r),
		.low_r(low_r)
	);

	assign enable = control_r[CDMOD_CON_ENABLE_BIT];
	assign sw_value = control_r[CDMOD_CON_SWVAL_BIT];
	assign out_invert = control_r[CDMOD_CON_INVERT_BIT];
	assign high_sync = high_r[CDMOD_CAR_SYNC_BIT];
	assign low_sync = low_r[CDMOD_CAR_SYNC_BIT];

	// [RULE16] Disabled: grounds and software bit, selections kept
	// [RULE7] Modulator source decode
	// [RULE5] Software value for code zero
	// [RULE8] Reserved codes give low
	// [RULE9] High carrier decode
	// [RULE10] Low carrier decode
	always_comb begin
		if (enable) begin
			mod_raw = cdmod_pick(mod_sources, source_r[3:0], sw_value);
			high_raw = cdmod_pick(carrier_sources, high_r[3:0], 1'b0);
			low_raw = cdmod_pick(carrier_sources, low_r[3:0], 1'b0);
		end else begin
			mod_raw = sw_value;
			high_raw = 1'b0;
			low_raw = 1'b0;
		end
	end

	// [RULE19] Inputs synchronised first
	cdmod_sync u_sync_mod (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(mod_raw),
		.sync_out(mod_s),
		.fall_pulse()
	);

	// [RULE11] High carrier polarity ahead of the edge detector
	// Sync then waits for a falling edge of the carrier as mixed, not of the raw pin
	cdmod_sync u_sync_high (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(high_raw ^ high_r[CDMOD_CAR_INVERT_BIT]),
		.sync_out(high_s),
		.fall_pulse(high_fall)
	);

	// [RULE12] Low carrier polarity ahead of the edge detector
	cdmod_sync u_sync_low (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(low_raw ^ low_r[CDMOD_CAR_INVERT_BIT]),
		.sync_out(low_s),
		.fall_pulse(low_fall)
	);

	// Carriers already carry their polarity
	assign high_car = high_s;
	assign low_car = low_s;

	// Gate state per carrier; wants = modulator selects this carrier
	function automatic cdmod_gate_type gate_step(input cdmod_gate_type st, input logic wants,
		input logic sync_en, input logic fall);
		cdmod_gate_type n;
		n = st;
		if (!sync_en) begin
			n = wants ? CDMOD_ST_ON : CDMOD_ST_IDLE;
		end else begin
			case (st)
				CDMOD_ST_IDLE: n = wants ? (fall ? CDMOD_ST_ON : CDMOD_ST_WAIT) : CDMOD_ST_IDLE;
				CDMOD_ST_WAIT: n = !wants ? CDMOD_ST_IDLE : (fall ? CDMOD_ST_ON : CDMOD_ST_WAIT);
				CDMOD_ST_ON: n = (!wants && fall) ? CDMOD_ST_IDLE : CDMOD_ST_ON;
				default: n = CDMOD_ST_IDLE;
			endcase
		end
		return n;
	endfunction : gate_step

	// [RULE13] High carrier falling-edge sync
	// [RULE14] Low carrier falling-edge sync
	// [RULE17] Leaving carrier holds until edge
	always_comb begin
		high_st_nxt = gate_step(high_st_r, mod_s, high_sync, high_fall);
		low_st_nxt = gate_step(low_st_r, ~mod_s, low_sync, low_fall);
	end

	// [RULE15] Mix: both may overlap during a sync handover
	always_comb begin
		mixed = ((high_st_r == CDMOD_ST_ON) & high_car) | ((low_st_r == CDMOD_ST_ON) & low_car);
		// [RULE1] No output while disabled
		// [RULE2] Polarity applies to idle level too
		out_nxt = (enable & mixed) ^ out_invert;
	end

	always_ff @(posedge aclk) begin
		// [RULE18] Reset idles the gates
		if (!aresetn) begin
			high_st_r <= CDMOD_ST_IDLE;
			low_st_r <= CDMOD_ST_IDLE;
			out_r <= 1'b0;
		end else begin
			high_st_r <= high_st_nxt;
			low_st_r <= low_st_nxt;
			out_r <= out_nxt;
		end
	end

	// [RULE4] Readback is the registered output, aliasing possible
	assign modulated_out = out_r;
endmodule : cdmod_top

//--- tb/cdmod_src_model.sv
// Model of the peripheral signal sources feeding the modulator
`timescale 1ns/1ps
module cdmod_src_model (
	input wire logic aclk,
	input wire logic slow,
	input wire logic [11:0] mod_set,
	input wire logic [11:0] car_set,
	output cdmod_pkg::cdmod_mod_src_type mod_sources,
	output cdmod_pkg::cdmod_car_src_type carrier_sources
);
	import cdmod_pkg::*;
	logic [23:0] stage_r;
	// Slow sources lag a cycle, like a peripheral on a divided clock
	always_ff @(posedge aclk) begin
		stage_r <= {mod_set, car_set};
		mod_sources <= slow ? stage_r[23:12] : mod_set;
		carrier_sources <= slow ? stage_r[11:0] : car_set;
	end
endmodule : cdmod_src_model

//--- tb/cdmod_top_properties.sv
// Checker: bus answers and reset behaviour of the modulator top
`timescale 1ns/1ps
module cdmod_top_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire cdmod_pkg::cdmod_axi_req_type axi_req,
	input wire cdmod_pkg::cdmod_axi_rsp_type axi_rsp,
	input wire cdmod_pkg::cdmod_mod_src_type mod_sources,
	input wire cdmod_pkg::cdmod_car_src_type carrier_sources,
	input wire logic modulated_out
);
	import cdmod_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_write_gets_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
		|=> axi_rsp.bvalid) else $error("write not answered");
	a_bvalid_one_beat: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
		else $error("bvalid stayed after bready");
	a_read_gets_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read not answered");
	a_rvalid_one_beat: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
		else $error("rvalid stayed after rready");
	a_write_blocked: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write taken while response pending");
	a_read_blocked: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
		else $error("read taken while data pending");
	a_upper_zero: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_reset_quiet: assert property (disable iff (1'h0) !aresetn |=> !modulated_out && !axi_rsp.bvalid && !axi_rsp.rvalid)
		else $error("outputs not cleared by reset");
endmodule : cdmod_top_properties

bind cdmod_top cdmod_top_properties u_props (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.mod_sources(mod_sources), .carrier_sources(carrier_sources), .modulated_out(modulated_out));

//--- tb/cdmod_top_test.sv
// Testbench of the carrier data modulator
`timescale 1ns/1ps
module cdmod_top_test;
	import cdmod_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic slow = 1'h0;
	logic [11:0] mset = 12'h0;
	logic [11:0] cset = 12'h0;
	cdmod_axi_req_type req = '0;
	cdmod_axi_rsp_type rsp;
	cdmod_mod_src_type msrc;
	cdmod_car_src_type csrc;
	logic mout;
	logic [7:0] regs [4];
	logic [1:0] resp;
	logic [31:0] rd;
	logic e;
	logic [3:0] strb = 4'hF;
	int failures = 0;
	int num_checks = 0;

	always #12.5 aclk = ~aclk;

	cdmod_src_model u_src (.aclk(aclk), .slow(slow), .mod_set(mset), .car_set(cset), .mod_sources(msrc),
		.carrier_sources(csrc));
	cdmod_top u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .mod_sources(msrc),
		.carrier_sources(csrc), .modulated_out(mout));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task conclude;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic aw = 1'h1;
		logic w = 1'h1;
		logic b = 1'h0;
		@(posedge aclk);
		req.awvalid <= 1'h1;
		req.awaddr <= a;
		req.wvalid <= 1'h1;
		req.wdata <= {24'h0, d};
		req.wstrb <= strb;
		req.bready <= 1'h1;
		while (!b) begin
			@(posedge aclk);
			if (aw && rsp.awready) begin
				aw = 1'h0;
				req.awvalid <= 1'h0;
			end
			if (w && rsp.wready) begin
				w = 1'h0;
				req.wvalid <= 1'h0;
			end
			if (rsp.bvalid) begin
				b = 1'h1;
				resp = rsp.bresp;
				req.bready <= 1'h0;
			end
		end
	endtask : wr

	task automatic rdr(input logic [3:0] a);
		logic ar = 1'h1;
		logic r = 1'h0;
		@(posedge aclk);
		req.arvalid <= 1'h1;
		req.araddr <= a;
		req.rready <= 1'h1;
		while (!r) begin
			@(posedge aclk);
			if (ar && rsp.arready) begin
				ar = 1'h0;
				req.arvalid <= 1'h0;
			end
			if (rsp.rvalid) begin
				r = 1'h1;
				rd = rsp.rdata;
				resp = rsp.rresp;
				req.rready <= 1'h0;
			end
		end
	endtask : rdr

	function automatic logic pick(input logic [11:0] v, input logic [3:0] c, input logic z);
		if (c == 4'h0) return z;
		if (c <= 4'h8) return v[c - 4'h1];
		if (c >= 4'hA && c <= 4'hD) return v[c - 4'h2];
		return 1'h0;
	endfunction : pick

	function automatic logic exp_out();
		logic md;
		logic hc;
		logic lc;
		if (!regs[0][7]) return regs[0][4];
		md = pick(mset, regs[1][3:0], regs[0][0]);
		hc = pick(cset, regs[2][3:0], 1'h0) ^ regs[2][6];
		lc = pick(cset, regs[3][3:0], 1'h0) ^ regs[3][6];
		return (md ? hc : lc) ^ regs[0][4];
	endfunction : exp_out

	// Sources pass two syncs and two stages, ten cycles is ample
	task automatic car0(input logic v, input logic x);
		@(posedge aclk);
		cset <= {11'h0, v};
		repeat (10) @(posedge aclk);
		check({31'h0, mout}, {31'h0, x});
	endtask : car0

	task automatic sync_case(input logic [3:0] a_s, input logic [3:0] a_o, input logic [7:0] on, input logic [7:0] off);
		wr(4'h4, 8'h00);
		wr(a_o, 8'h00);
		wr(a_s, 8'h21);
		wr(4'h0, off);
		car0(1'h0, 1'h0);
		car0(1'h1, 1'h0);
		wr(4'h0, on);
		car0(1'h1, 1'h0);
		car0(1'h0, 1'h0);
		car0(1'h1, 1'h1);
		wr(4'h0, off);
		car0(1'h1, 1'h1);
		car0(1'h0, 1'h0);
		car0(1'h1, 1'h0);
	endtask : sync_case

	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		conclude();
	end

	initial begin
		void'($urandom(55675));
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		for (int k = 0; k < 4; k++) begin
			rdr(4'(4 * k));
			check(rd, 32'h0);
		end
		wr(4'h2, 8'hFF);
		check({30'h0, resp}, {30'h0, CDMOD_RESP_SLVERR});
		rdr(4'h2);
		check(rd, 32'h0);
		check({30'h0, resp}, {30'h0, CDMOD_RESP_SLVERR});
		// Lane 0 strobe low: register must keep its value
		strb = 4'h0;
		wr(4'h4, 8'h0F);
		strb = 4'hF;
		rdr(4'h4);
		check(rd, 32'h0);
		for (int i = 0; i < 48; i++) begin
			for (int k = 0; k < 4; k++) regs[k] = 8'($urandom);
			// Sweep every code of all three selectors, sync off
			regs[1][3:0] = i[3:0];
			regs[2][3:0] = i[3:0] + 4'h5;
			regs[3][3:0] = i[3:0] + 4'h9;
			regs[2][5] = 1'h0;
			regs[3][5] = 1'h0;
			mset <= 12'($urandom);
			cset <= 12'($urandom);
			slow <= 1'($urandom);
			for (int k = 0; k < 4; k++) wr(4'(4 * k), regs[k]);
			check({30'h0, resp}, {30'h0, CDMOD_RESP_OKAY});
			for (int k = 1; k < 4; k++) begin
				rdr(4'(4 * k));
				check(rd, {24'h0, regs[k] & (k == 1 ? 8'h0F : 8'h6F)});
			end
			repeat (10) @(posedge aclk);
			e = exp_out();
			check({31'h0, mout}, {31'h0, e});
			rdr(4'h0);
			check(rd, {24'h0, regs[0] & 8'h91 | {4'h0, e, 3'h0}});
		end
		// Disable then re-enable: selections must survive
		regs[0][7] = 1'h0;
		wr(4'h0, regs[0]);
		repeat (10) @(posedge aclk);
		check({31'h0, mout}, {31'h0, exp_out()});
		regs[0][7] = 1'h1;
		wr(4'h0, regs[0]);
		repeat (10) @(posedge aclk);
		check({31'h0, mout}, {31'h0, exp_out()});
		slow <= 1'h0;
		sync_case(4'h8, 4'hC, 8'h81, 8'h80);
		sync_case(4'hC, 4'h8, 8'h80, 8'h81);
		wr(4'h0, 8'h90);
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		check({31'h0, mout}, 32'h0);
		aresetn <= 1'h1;
		for (int k = 0; k < 4; k++) begin
			rdr(4'(4 * k));
			check(rd, 32'h0);
		end
		conclude();
	end
endmodule : cdmod_top_test
